// ### dtc_pkg.sv
// constants, register map and types shared by the dual timer/event counter
package dtc_pkg;

  // register addresses on the register port
  localparam logic [7:0] ADDR_INTR_CTRL = 8'h0B;
  localparam logic [7:0] ADDR_SHORT_VALUE = 8'h0D;
  localparam logic [7:0] ADDR_SHORT_CTRL = 8'h0E;
  localparam logic [7:0] ADDR_LONG_HIGH = 8'h0F;
  localparam logic [7:0] ADDR_LONG_LOW = 8'h10;
  localparam logic [7:0] ADDR_LONG_CTRL = 8'h11;

  // control register fields, same layout on both counters except prescaler bits 2:0, short counter only
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int EN_BIT = 4;
  localparam int EDGE_BIT = 3;
  localparam int PSC_HI = 2;
  localparam int PSC_LO = 0;

  // interrupt control register fields
  localparam int SHORT_FLAG_BIT = 5;
  localparam int LONG_FLAG_BIT = 6;
  localparam int SHORT_IE_BIT = 2;
  localparam int LONG_IE_BIT = 3;

  // writable bits; all others read as zero
  localparam logic [7:0] SHORT_CTRL_MASK = 8'hDF;
  localparam logic [7:0] LONG_CTRL_MASK = 8'hD8;
  localparam logic [7:0] INTR_CTRL_MASK = 8'h6C;

  // values after reset
  localparam logic [7:0] SHORT_CTRL_RST = 8'h08;
  localparam logic [7:0] LONG_CTRL_RST = 8'h08;
  localparam logic [7:0] INTR_CTRL_RST = 8'h00;
  localparam logic [7:0] SHORT_CNT_RST = 8'h00;
  localparam logic [15:0] LONG_CNT_RST = 16'h0000;

  // mode field encodings
  localparam logic [1:0] MODE_EVENT = 2'h1;
  localparam logic [1:0] MODE_TIMER = 2'h2;
  localparam logic [1:0] MODE_PULSE = 2'h3;

  // terminal counts
  localparam logic [7:0] SHORT_MAX = 8'hFF;
  localparam logic [15:0] LONG_MAX = 16'hFFFF;

  // prescaler: base shift pattern gives divide by 2 at code 000
  localparam logic [7:0] PSC_BASE = 8'hFE;
  // instruction clock is the system clock divided by four
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;

  typedef enum logic [1:0] {
    DTC_PW_IDLE = 2'b01,
    DTC_PW_MEAS = 2'b10
  } dtc_pw_e;

endpackage

// ### dtc_pin_if.sv
// synchronised timer pin: level and one-cycle edge pulses
`timescale 1ns/10ps
interface dtc_pin_if;
  logic level;
  logic rise;
  logic fall;
  modport src(output level, output rise, output fall);
  modport dst(input level, input rise, input fall);
endinterface

// ### dtc_pin_sync.sv
// two-flop synchroniser and edge detector for one timer input pin
`timescale 1ns/10ps
module dtc_pin_sync import dtc_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_pin,
  dtc_pin_if.src pin
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } dtc_sync_s;

  dtc_sync_s r;
  dtc_sync_s next_r;

  always_comb begin
    next_r = r;
    next_r.meta = i_pin;
    next_r.sync = r.meta;
    next_r.prev = r.sync;
    if (i_rst) begin
      next_r = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    r <= next_r;
  end

  // edges come only from the second and third stages
  assign pin.level = r.sync;
  assign pin.rise = r.sync & ~r.prev;
  assign pin.fall = ~r.sync & r.prev;

endmodule

// ### dtc_prescaler.sv
// internal clock prescaler for the short counter and divide-by-four instruction tick
`timescale 1ns/10ps
module dtc_prescaler import dtc_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_psc,
  output logic o_short_tick,
  output logic o_instr_tick
);

  typedef struct packed {
    logic [7:0] div;
    logic [1:0] instr;
  } dtc_psc_s;

  dtc_psc_s r;
  dtc_psc_s next_r;
  logic [7:0] mask;

  always_comb begin
    next_r = r;
    next_r.div = r.div + 8'h01;
    next_r.instr = r.instr + 2'h1;
    if (i_rst) begin
      next_r = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    r <= next_r;
  end

  // code n gives one tick every 2^(n+1) system clocks
  assign mask = ~(PSC_BASE << i_psc);
  assign o_short_tick = (r.div & mask) == mask;
  assign o_instr_tick = r.instr == INSTR_DIV_LAST;

endmodule

// ### dtc_top.sv
// dual timer/event counter: 8-bit short counter and 16-bit long counter
//
// Behaviour
// - short counter is 8-bit up-counter, from pin or prescaled clock
// - long counter is 16-bit up-counter, from pin or system clock divided by four
// - short counter drives divider output, frequency input/(2*(256-N))
// - short value write loads preload and counter when off, preload only when on
// - short value read returns live count, blocks that cycle's count
// - mode field bits 7:6: 01 event, 10 timer, 11 pulse width, 00 unused
// - short counts to FFH, reloads from preload and sets flag bit 5
// - long counts to FFFFH, reloads from preload and sets flag bit 6
// - short pulse mode counts from selected edge to return, then clears enable
// - long pulse mode counts instruction clock, clears enable, waits for re-enable
// - overflow during pulse measurement reloads and flags as other modes
// - enable is bit 4; software clears it, pulse mode completion clears it too
// - long enable at bit 4: 0 stops counting, 1 runs it
// - any overflow pulses the wake-up output
// - clear interrupt enable bit keeps overflow from requesting service
// - short prescaler code 000 divides by 2, doubling up to 256 at 111
// - short control bit 3 picks active pin edge; bit 5 reads zero
// - long control bit 3 picks active pin edge; bits 2:0 and 5 read zero
// - long low write goes to buffer; high write loads preload with buffer
// - long high read returns high byte, copies low byte to buffer, blocks count
// - long preload write also loads counter only while counter is disabled
// - long timer mode counts instruction ticks, event mode counts pin edges
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
module dtc_top import dtc_pkg::*; (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  input wire logic I_SHORT_COUNTER_PIN,
  input wire logic I_LONG_COUNTER_PIN,
  output logic O_FREQUENCY_DIVIDER_OUTPUT,
  output logic O_WAKEUP,
  output logic O_SHORT_IRQ,
  output logic O_LONG_IRQ
);

  typedef struct packed {
    logic [7:0] short_counter;
    logic [7:0] short_preload;
    logic [7:0] short_counter_control;
    dtc_pw_e short_pw;
    logic [15:0] long_counter;
    logic [15:0] long_preload;
    logic [7:0] long_low_buffer;
    logic [7:0] long_counter_control;
    dtc_pw_e long_pw;
    logic [7:0] interrupt_control_register;
    logic [7:0] rdata;
    logic freq_div;
    logic wakeup;
    logic short_irq;
    logic long_irq;
  } dtc_top_s;

  dtc_top_s r;
  dtc_top_s next_r;

  logic short_tick;
  logic instr_tick;

  dtc_pin_if short_pin ();
  dtc_pin_if long_pin ();

  dtc_pin_sync u_short_sync (
    .i_clk(I_CLK_SYS),
    .i_rst(I_RST),
    .i_pin(I_SHORT_COUNTER_PIN),
    .pin(short_pin)
  );

  dtc_pin_sync u_long_sync (
    .i_clk(I_CLK_SYS),
    .i_rst(I_RST),
    .i_pin(I_LONG_COUNTER_PIN),
    .pin(long_pin)
  );

  // free running; control writes do not restart the divider
  dtc_prescaler u_prescaler (
    .i_clk(I_CLK_SYS),
    .i_rst(I_RST),
    .i_psc(r.short_counter_control[PSC_HI:PSC_LO]),
    .o_short_tick(short_tick),
    .o_instr_tick(instr_tick)
  );

  always_comb begin
    logic wr_short_value;
    logic wr_short_ctrl;
    logic wr_long_high;
    logic wr_long_low;
    logic wr_long_ctrl;
    logic wr_intr;
    logic rd_short_value;
    logic rd_long_high;
    logic s_en;
    logic s_act;
    logic s_ret;
    logic s_inc;
    logic s_ovf;
    logic s_done;
    logic [1:0] s_mode;
    logic l_en;
    logic l_act;
    logic l_ret;
    logic l_inc;
    logic l_ovf;
    logic l_done;
    logic [1:0] l_mode;

    wr_short_value = 1'b0;
    wr_short_ctrl = 1'b0;
    wr_long_high = 1'b0;
    wr_long_low = 1'b0;
    wr_long_ctrl = 1'b0;
    wr_intr = 1'b0;
    rd_short_value = 1'b0;
    rd_long_high = 1'b0;
    s_inc = 1'b0;
    s_done = 1'b0;
    l_inc = 1'b0;
    l_done = 1'b0;
    // every local starts defined so no path keeps a stale value
    s_en = 1'b0;
    s_act = 1'b0;
    s_ret = 1'b0;
    s_ovf = 1'b0;
    s_mode = 2'h0;
    l_en = 1'b0;
    l_act = 1'b0;
    l_ret = 1'b0;
    l_ovf = 1'b0;
    l_mode = 2'h0;

    next_r = r;
    next_r.rdata = 8'h00;
    next_r.wakeup = 1'b0;

    // address decode
    if (I_ADDR == ADDR_SHORT_VALUE) begin
      wr_short_value = I_WR;
      rd_short_value = I_RD;
    end else if (I_ADDR == ADDR_SHORT_CTRL) begin
      wr_short_ctrl = I_WR;
    end else if (I_ADDR == ADDR_LONG_HIGH) begin
      wr_long_high = I_WR;
      rd_long_high = I_RD;
    end else if (I_ADDR == ADDR_LONG_LOW) begin
      wr_long_low = I_WR;
    end else if (I_ADDR == ADDR_LONG_CTRL) begin
      wr_long_ctrl = I_WR;
    end else if (I_ADDR == ADDR_INTR_CTRL) begin
      wr_intr = I_WR;
    end

    // short counter
    s_mode = r.short_counter_control[MODE_HI:MODE_LO];
    s_en = r.short_counter_control[EN_BIT];
    s_act = r.short_counter_control[EDGE_BIT] ? short_pin.fall : short_pin.rise;
    s_ret = r.short_counter_control[EDGE_BIT] ? short_pin.rise : short_pin.fall;

    // mode 00 or a clear enable leaves the count frozen
    case (s_mode)
      MODE_EVENT: s_inc = s_en & s_act;
      MODE_TIMER: s_inc = s_en & short_tick;
      MODE_PULSE: s_inc = s_en & (r.short_pw == DTC_PW_MEAS) & short_tick;
      default: s_inc = 1'b0;
    endcase

    // a read freezes the count for that cycle; the tick is lost, not deferred
    if (rd_short_value) begin
      s_inc = 1'b0;
    end

    // arming needs the enable bit, so a finished result is held
    case (r.short_pw)
      DTC_PW_IDLE: begin
        if (s_mode == MODE_PULSE && s_en && s_act) begin
          next_r.short_pw = DTC_PW_MEAS;
        end
      end
      DTC_PW_MEAS: begin
        if (!s_en || s_mode != MODE_PULSE) begin
          next_r.short_pw = DTC_PW_IDLE;
        end else if (s_ret) begin
          next_r.short_pw = DTC_PW_IDLE;
          s_done = 1'b1;
        end
      end
      default: next_r.short_pw = DTC_PW_IDLE;
    endcase

    s_ovf = s_inc && (r.short_counter == SHORT_MAX);
    if (s_inc) begin
      if (s_ovf) begin
        next_r.short_counter = r.short_preload;
        next_r.freq_div = ~r.freq_div;
      end else begin
        next_r.short_counter = r.short_counter + 8'h01;
      end
    end

    if (s_done) begin
      next_r.short_counter_control[EN_BIT] = 1'b0;
    end
    // a software write in the completion cycle wins over the hardware clear
    if (wr_short_ctrl) begin
      next_r.short_counter_control = I_WDATA & SHORT_CTRL_MASK;
    end
    if (wr_short_value) begin
      next_r.short_preload = I_WDATA;
      if (!s_en) begin
        next_r.short_counter = I_WDATA;
      end
    end

    // long counter
    l_mode = r.long_counter_control[MODE_HI:MODE_LO];
    l_en = r.long_counter_control[EN_BIT];
    l_act = r.long_counter_control[EDGE_BIT] ? long_pin.fall : long_pin.rise;
    l_ret = r.long_counter_control[EDGE_BIT] ? long_pin.rise : long_pin.fall;

    case (l_mode)
      MODE_EVENT: l_inc = l_en & l_act;
      MODE_TIMER: l_inc = l_en & instr_tick;
      MODE_PULSE: l_inc = l_en & (r.long_pw == DTC_PW_MEAS) & instr_tick;
      default: l_inc = 1'b0;
    endcase

    if (rd_long_high) begin
      l_inc = 1'b0;
    end

    // same measurement sequence, timed by instruction ticks
    case (r.long_pw)
      DTC_PW_IDLE: begin
        if (l_mode == MODE_PULSE && l_en && l_act) begin
          next_r.long_pw = DTC_PW_MEAS;
        end
      end
      DTC_PW_MEAS: begin
        if (!l_en || l_mode != MODE_PULSE) begin
          next_r.long_pw = DTC_PW_IDLE;
        end else if (l_ret) begin
          next_r.long_pw = DTC_PW_IDLE;
          l_done = 1'b1;
        end
      end
      default: next_r.long_pw = DTC_PW_IDLE;
    endcase

    l_ovf = l_inc && (r.long_counter == LONG_MAX);
    if (l_inc) begin
      if (l_ovf) begin
        next_r.long_counter = r.long_preload;
      end else begin
        next_r.long_counter = r.long_counter + 16'h0001;
      end
    end

    if (l_done) begin
      next_r.long_counter_control[EN_BIT] = 1'b0;
    end
    if (wr_long_ctrl) begin
      next_r.long_counter_control = I_WDATA & LONG_CTRL_MASK;
    end
    if (wr_long_low) begin
      next_r.long_low_buffer = I_WDATA;
    end
    // high byte write commits the buffered low byte with it
    if (wr_long_high) begin
      next_r.long_preload = {I_WDATA, r.long_low_buffer};
      if (!l_en) begin
        next_r.long_counter = {I_WDATA, r.long_low_buffer};
      end
    end

    // interrupt flags: an overflow in the clearing cycle still sets the flag
    if (wr_intr) begin
      next_r.interrupt_control_register = I_WDATA & INTR_CTRL_MASK;
    end
    if (s_ovf) begin
      next_r.interrupt_control_register[SHORT_FLAG_BIT] = 1'b1;
    end
    if (l_ovf) begin
      next_r.interrupt_control_register[LONG_FLAG_BIT] = 1'b1;
    end
    next_r.short_irq = next_r.interrupt_control_register[SHORT_FLAG_BIT]
      & next_r.interrupt_control_register[SHORT_IE_BIT];
    next_r.long_irq = next_r.interrupt_control_register[LONG_FLAG_BIT]
      & next_r.interrupt_control_register[LONG_IE_BIT];
    next_r.wakeup = s_ovf | l_ovf;

    // read data, valid only in the cycle after the strobe
    if (I_RD) begin
      if (I_ADDR == ADDR_SHORT_VALUE) begin
        next_r.rdata = r.short_counter;
      end else if (I_ADDR == ADDR_SHORT_CTRL) begin
        next_r.rdata = r.short_counter_control & SHORT_CTRL_MASK;
      end else if (I_ADDR == ADDR_LONG_HIGH) begin
        next_r.rdata = r.long_counter[15:8];
        next_r.long_low_buffer = r.long_counter[7:0];
      end else if (I_ADDR == ADDR_LONG_LOW) begin
        next_r.rdata = r.long_low_buffer;
      end else if (I_ADDR == ADDR_LONG_CTRL) begin
        next_r.rdata = r.long_counter_control & LONG_CTRL_MASK;
      end else if (I_ADDR == ADDR_INTR_CTRL) begin
        next_r.rdata = r.interrupt_control_register;
      end else begin
        next_r.rdata = 8'h00;
      end
    end

    // reset last so it overrides every bus and counter update
    if (I_RST) begin
      next_r = '0;
      next_r.short_counter = SHORT_CNT_RST;
      next_r.long_counter = LONG_CNT_RST;
      next_r.short_counter_control = SHORT_CTRL_RST;
      next_r.long_counter_control = LONG_CTRL_RST;
      next_r.interrupt_control_register = INTR_CTRL_RST;
      next_r.short_pw = DTC_PW_IDLE;
      next_r.long_pw = DTC_PW_IDLE;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    r <= next_r;
  end

  assign O_RDATA = r.rdata;
  assign O_FREQUENCY_DIVIDER_OUTPUT = r.freq_div;
  assign O_WAKEUP = r.wakeup;
  assign O_SHORT_IRQ = r.short_irq;
  assign O_LONG_IRQ = r.long_irq;

endmodule

// ### dtc_monitor.sv
// port-level assertion checker for the dual timer/event counter
`timescale 1ns/10ps
module dtc_monitor import dtc_pkg::*; (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [7:0] O_RDATA,
  input wire logic I_SHORT_COUNTER_PIN,
  input wire logic I_LONG_COUNTER_PIN,
  input wire logic O_FREQUENCY_DIVIDER_OUTPUT,
  input wire logic O_WAKEUP,
  input wire logic O_SHORT_IRQ,
  input wire logic O_LONG_IRQ
);
  logic s_ie;
  logic l_ie;
  // interrupt enables mirrored from bus writes
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      s_ie <= 1'b0;
      l_ie <= 1'b0;
    end else if (I_WR && I_ADDR == ADDR_INTR_CTRL) begin
      s_ie <= I_WDATA[SHORT_IE_BIT];
      l_ie <= I_WDATA[LONG_IE_BIT];
    end
  end
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RST);
  sequence s_wr(a);
    I_WR && I_ADDR == a;
  endsequence
  sequence s_rd(a);
    I_RD && I_ADDR == a;
  endsequence
  property p_rd_idle;
    !$past(I_RD) |-> O_RDATA == 8'h00;
  endproperty
  property p_fdo_wake;
    $changed(O_FREQUENCY_DIVIDER_OUTPUT) |-> O_WAKEUP;
  endproperty
  property p_sirq;
    O_SHORT_IRQ |-> s_ie;
  endproperty
  property p_lirq;
    O_LONG_IRQ |-> l_ie;
  endproperty
  // a rise not caused by a bus write must come from an overflow
  property p_irq_wake;
    ($rose(O_SHORT_IRQ) || $rose(O_LONG_IRQ)) && !$past(I_WR) |-> O_WAKEUP;
  endproperty
  property p_sctl;
    s_wr(ADDR_SHORT_CTRL) ##1 I_RD && I_ADDR == ADDR_SHORT_CTRL
      && $past(I_WDATA[7:6]) != MODE_PULSE |=> O_RDATA == ($past(I_WDATA, 2) & SHORT_CTRL_MASK);
  endproperty
  property p_lctl;
    s_wr(ADDR_LONG_CTRL) ##1 I_RD && I_ADDR == ADDR_LONG_CTRL
      && $past(I_WDATA[7:6]) != MODE_PULSE |=> O_RDATA == ($past(I_WDATA, 2) & LONG_CTRL_MASK);
  endproperty
  property p_lbuf;
    s_wr(ADDR_LONG_LOW) ##1 s_rd(ADDR_LONG_LOW) |=> O_RDATA == $past(I_WDATA, 2);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  a_fdo_wake: assert property (p_fdo_wake) else $error("divider toggle without overflow");
  a_sirq: assert property (p_sirq) else $error("short request while masked");
  a_lirq: assert property (p_lirq) else $error("long request while masked");
  a_irq_wake: assert property (p_irq_wake) else $error("request without wake-up");
  a_sctl: assert property (p_sctl) else $error("short control readback wrong");
  a_lctl: assert property (p_lctl) else $error("long control readback wrong");
  a_lbuf: assert property (p_lbuf) else $error("low byte buffer readback wrong");
endmodule
bind dtc_top dtc_monitor u_mon (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_ADDR(I_ADDR),
  .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .I_SHORT_COUNTER_PIN(I_SHORT_COUNTER_PIN), .I_LONG_COUNTER_PIN(I_LONG_COUNTER_PIN),
  .O_FREQUENCY_DIVIDER_OUTPUT(O_FREQUENCY_DIVIDER_OUTPUT), .O_WAKEUP(O_WAKEUP),
  .O_SHORT_IRQ(O_SHORT_IRQ), .O_LONG_IRQ(O_LONG_IRQ));

// ### dtc_pin_src.sv
// external event or pulse source in front of one timer pin
`timescale 1ns/10ps
module dtc_pin_src (
  input wire logic i_clk,
  output logic o_pin
);
  initial o_pin = 1'b0;
  // n pulses, hi cycles high then lo cycles low
  task automatic pulses(input int n, input int hi, input int lo);
    repeat (n) begin
      @(posedge i_clk);
      o_pin <= 1'b1;
      repeat (hi) @(posedge i_clk);
      o_pin <= 1'b0;
      repeat (lo) @(posedge i_clk);
    end
  endtask
endmodule

// ### tb_top.sv
// self-checking testbench for the dual timer/event counter
`timescale 1ns/10ps
module tb_top import dtc_pkg::*; ;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic spin;
  logic lpin;
  logic fdo;
  logic wake;
  logic sirq;
  logic lirq;
  int failures = 0;
  int n_tests = 0;
  dtc_pin_src u_ssrc (.i_clk(clk), .o_pin(spin));
  dtc_pin_src u_lsrc (.i_clk(clk), .o_pin(lpin));
  dtc_top u_dut (.I_CLK_SYS(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_SHORT_COUNTER_PIN(spin), .I_LONG_COUNTER_PIN(lpin),
    .O_FREQUENCY_DIVIDER_OUTPUT(fdo), .O_WAKEUP(wake), .O_SHORT_IRQ(sirq), .O_LONG_IRQ(lirq));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // write then read back with no gap
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] v);
    wr_reg(a, d);
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // bounded wait; returns cycles from the call up to the next wake-up
  task automatic wait_wake(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (wake !== 1'b1 && n < 5000);
  endtask
  task automatic t_regs();
    logic [7:0] v;
    rd_reg(ADDR_SHORT_CTRL, v);
    chk(v, SHORT_CTRL_RST);
    rd_reg(ADDR_LONG_CTRL, v);
    chk(v, LONG_CTRL_RST);
    rd_reg(8'h20, v);
    chk(v, 8'h00);
    wr_rd(ADDR_SHORT_CTRL, 8'h2F, v);
    chk(v, 8'h0F);
    wr_rd(ADDR_LONG_CTRL, 8'h6F, v);
    chk(v, 8'h48);
    wr_rd(ADDR_LONG_LOW, 8'hA5, v);
    chk(v, 8'hA5);
    wr_reg(ADDR_LONG_HIGH, 8'h3C);
    rd_reg(ADDR_LONG_HIGH, v);
    chk(v, 8'h3C);
    rd_reg(ADDR_LONG_LOW, v);
    chk(v, 8'hA5);
  endtask
  task automatic t_psc();
    int n;
    logic f;
    logic [7:0] h;
    logic [7:0] v;
    wr_reg(ADDR_INTR_CTRL, 8'h04);
    wr_reg(ADDR_SHORT_VALUE, 8'hF0);
    for (int c = 0; c < 8; c++) begin
      wr_reg(ADDR_SHORT_CTRL, {MODE_TIMER, 3'h2, c[2:0]});
      wait_wake(n);
      f = fdo;
      wait_wake(n);
      chk(n, 16 << (c + 1));
      chk(fdo ^ f, 1'b1);
    end
    chk(sirq, 1'b1);
    rd_reg(ADDR_INTR_CTRL, v);
    chk(v[SHORT_FLAG_BIT], 1'b1);
    // mode 00 with enable set must not count
    wr_reg(ADDR_SHORT_CTRL, 8'h10);
    rd_reg(ADDR_SHORT_VALUE, v);
    repeat (20) @(posedge clk);
    rd_reg(ADDR_SHORT_VALUE, h);
    chk(h, v);
    wr_reg(ADDR_SHORT_CTRL, 8'h00);
  endtask
  task automatic t_long();
    int n;
    logic [7:0] v;
    wr_reg(ADDR_INTR_CTRL, 8'h00);
    wr_reg(ADDR_LONG_LOW, 8'hF0);
    wr_reg(ADDR_LONG_HIGH, 8'hFF);
    wr_reg(ADDR_LONG_CTRL, 8'h90);
    wait_wake(n);
    wait_wake(n);
    chk(n, 64);
    chk(lirq, 1'b0);
    rd_reg(ADDR_INTR_CTRL, v);
    chk(v[LONG_FLAG_BIT], 1'b1);
    wr_reg(ADDR_INTR_CTRL, 8'h08);
    wait_wake(n);
    chk(wake, 1'b1);
    chk(lirq, 1'b1);
    wr_reg(ADDR_LONG_CTRL, 8'h80);
  endtask
  task automatic t_event();
    logic [7:0] v;
    wr_reg(ADDR_SHORT_VALUE, 8'hFD);
    wr_reg(ADDR_SHORT_CTRL, 8'h58);
    // while counting, a value write only reaches the preload
    wr_reg(ADDR_SHORT_VALUE, 8'hF0);
    u_ssrc.pulses(2, 3, 3);
    rd_reg(ADDR_SHORT_VALUE, v);
    chk(v, 8'hFF);
    wr_reg(ADDR_SHORT_CTRL, 8'h50);
    u_ssrc.pulses(1, 3, 3);
    rd_reg(ADDR_SHORT_VALUE, v);
    chk(v, 8'hF0);
    wr_reg(ADDR_LONG_LOW, 8'hFE);
    wr_reg(ADDR_LONG_HIGH, 8'hFF);
    wr_reg(ADDR_LONG_CTRL, 8'h50);
    wr_reg(ADDR_LONG_LOW, 8'h00);
    wr_reg(ADDR_LONG_HIGH, 8'h80);
    u_lsrc.pulses(2, 3, 3);
    rd_reg(ADDR_LONG_HIGH, v);
    chk(v, 8'h80);
    rd_reg(ADDR_LONG_LOW, v);
    chk(v, 8'h00);
    // falling edge only: one pulse adds exactly one
    wr_reg(ADDR_LONG_CTRL, 8'h58);
    u_lsrc.pulses(1, 3, 3);
    rd_reg(ADDR_LONG_HIGH, v);
    chk(v, 8'h80);
    rd_reg(ADDR_LONG_LOW, v);
    chk(v, 8'h01);
  endtask
  task automatic t_pulse();
    logic [7:0] v;
    logic [7:0] h;
    wr_reg(ADDR_SHORT_CTRL, 8'h00);
    wr_reg(ADDR_SHORT_VALUE, 8'h00);
    wr_reg(ADDR_SHORT_CTRL, 8'hD0);
    u_ssrc.pulses(1, 40, 8);
    rd_reg(ADDR_SHORT_CTRL, v);
    chk(v, 8'hC0);
    rd_reg(ADDR_SHORT_VALUE, h);
    chk(h >= 8'h12 && h <= 8'h16, 1'b1);
    u_ssrc.pulses(1, 20, 8);
    rd_reg(ADDR_SHORT_VALUE, v);
    chk(v, h);
    wr_reg(ADDR_LONG_CTRL, 8'h00);
    wr_reg(ADDR_LONG_LOW, 8'h00);
    wr_reg(ADDR_LONG_HIGH, 8'h00);
    wr_reg(ADDR_LONG_CTRL, 8'hD0);
    u_lsrc.pulses(1, 80, 8);
    rd_reg(ADDR_LONG_CTRL, v);
    chk(v, 8'hC0);
    rd_reg(ADDR_LONG_HIGH, v);
    chk(v, 8'h00);
    rd_reg(ADDR_LONG_LOW, h);
    chk(h >= 8'h12 && h <= 8'h16, 1'b1);
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // the prescaler sweep dominates the run at about 130 us
  initial begin
    #500000;
    failures++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_psc();
    t_long();
    t_event();
    t_pulse();
    stop_test();
  end
endmodule
